// >>> hw/uef_regs.sv
// event flags, fifo control and link format registers of a serial/ir port
//
// What this block does
// - extended mode shows every event source as its own pending flag
// - event register read clears only the dma event, others clear at source
// - rx high event: holding full, or fifo at threshold or timeout
// - tx low event: holding empty, or fifo below threshold
// - link event on receive error or break; fifo errors reported at bottom
// - consumer ir: link event on receiver overrun or transmitter underrun
// - modem event from modem status bits 0..3, forced 0 when ir select set outside uart mode
// - dma event set by terminal count, cleared by event register read
// - tx empty event mirrors line status bit 6; bits 7 and 6 read 0
// - fifo enable turns both fifos on, clearing empties; forced in consumer ir
// - rx soft reset empties rx fifo, resets receiver, self clears
// - tx soft reset empties tx fifo, resets transmitter, self clears
// - tx threshold codes give 1,3,9,13 or 1,7,17,25 entries
// - rx threshold codes give 1,4,8,14 or 1,8,16,26 entries
// - read at format address returns bank select; format via bank 3 shadow
// - bit 7 low writes both; high and not bank 1 writes bank select only
// - format bits 6..0 ignored in consumer ir mode
// - char length codes select 5,6,7,8 bits, 5 after reset
// - stop bit: 1, or 1.5 for 5 bits else 2; receiver checks one
// - parity: none, odd, even, constant one, constant zero
// - break drives only the transmit front end
// - bank select: bit 7 low means bank 0, else bits 6..0 encode bank
// - mode field in bits 7..5 picks uart, keyed ir, sir or consumer ir
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps

module uef_regs
  import uef_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter bit LEGACY_DMA = 1'b1
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // register port
  input  wire logic [2:0]          addr,
  input  wire logic [7:0]          wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic [7:0]               rdata,
  // path status and clear strobes
  input  wire uef_pkg::uef_path_t  path,
  input  wire uef_pkg::uef_ack_t   ack,
  // controls to the serial engine
  output logic                     fifo_on,
  output logic                     rx_flush,
  output logic                     tx_flush,
  output uef_pkg::uef_format_t     format,
  output logic [2:0]               op_mode_sel,
  output logic [6:0]               active_bank
);

  import uef_pkg::*;

  logic [7:0] line_format;
  logic [7:0] bank_select;
  logic [7:0] fifo_control;
  logic [7:0] mode_control;
  logic [7:0] ir_control_two;
  logic       link_pend;
  logic       modem_pend;
  logic       dma_tc_event;
  logic       cir;
  logic       fifo_eff;
  logic [5:0] tx_thresh;
  logic [5:0] rx_thresh;
  logic [7:0] event_flags_ext;
  logic       bank1_code;
  logic       ev_read;

  assign cir        = (mode_control[7:UEF_MODE_LSB] == UEF_MODE_CIR);
  assign fifo_eff   = cir | fifo_control[UEF_FC_EN];
  assign ev_read    = rd && (addr == UEF_OFF_EVENT);
  // codes that land in bank 1 still let the line format be written
  assign bank1_code = wdata[7] &&
                      (!wdata[6] || wdata[1] || wdata[0]);

  // thresholds follow the fifo depth
  always_comb begin
    if (FIFO_DEPTH > 16) begin
      tx_thresh = UEF_TX32[fifo_control[UEF_FC_TXTH +: 2]];
      rx_thresh = UEF_RX32[fifo_control[UEF_FC_RXTH +: 2]];
    end else begin
      tx_thresh = UEF_TX16[fifo_control[UEF_FC_TXTH +: 2]];
      rx_thresh = UEF_RX16[fifo_control[UEF_FC_RXTH +: 2]];
    end
  end

  // event flags assembled from live levels and sticky pendings
  always_comb begin
    event_flags_ext = 8'h00;
    event_flags_ext[UEF_EV_RXHDL] = fifo_eff ?
        ((path.rx_level >= rx_thresh) | path.rx_timeout) :
        path.rx_holding_full;
    event_flags_ext[UEF_EV_TXLDL] = fifo_eff ?
        (path.tx_level < tx_thresh) : path.tx_holding_empty;
    event_flags_ext[UEF_EV_LINK]  = link_pend;
    event_flags_ext[UEF_EV_MODEM] = modem_pend &
        ((mode_control[7:UEF_MODE_LSB] == UEF_MODE_UART) |
         !ir_control_two[UEF_IRSEL]);
    event_flags_ext[UEF_EV_DMA]   = dma_tc_event;
    event_flags_ext[UEF_EV_TX_EMPTY_STATUS] = path.tx_empty_status;
  end

  // link event: errors arrive already aligned to the fifo bottom upstream
  always_ff @(posedge clk) begin
    if (!rstn || rx_flush) begin
      link_pend <= 1'b0;
    end else if (cir ? (path.rx_overrun | path.tx_underrun) :
                 (path.rx_overrun | path.parity_error |
                  path.framing_error | path.break_detect)) begin
      link_pend <= 1'b1;
    end else if (ack.line_status_read) begin
      link_pend <= 1'b0;
    end
  end

  // modem event: set wins over the clear from a status read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      modem_pend <= 1'b0;
    end else if (|path.modem_status_bits) begin
      modem_pend <= 1'b1;
    end else if (ack.modem_status_read) begin
      modem_pend <= 1'b0;
    end
  end

  // dma terminal count event, the only flag an event read clears
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dma_tc_event <= 1'b0;
    end else if (LEGACY_DMA && path.terminal_count) begin
      dma_tc_event <= 1'b1;
    end else if (ev_read) begin
      dma_tc_event <= 1'b0;
    end
  end

  // fifo control; soft reset bits never stored, and a read at this address returns the event flags instead
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fifo_control <= UEF_FC_RESET;
    end else if (wr && addr == UEF_OFF_EVENT) begin
      fifo_control <= {wdata[7:4], 1'b0, 2'b00, wdata[UEF_FC_EN]};
    end
  end

  // flush pulses last one cycle after the causing write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_flush <= 1'b0;
      tx_flush <= 1'b0;
      fifo_on  <= 1'b0;
    end else begin
      rx_flush <= wr && addr == UEF_OFF_EVENT &&
                  (wdata[UEF_FC_RX_SOFT_RESET] || (!wdata[UEF_FC_EN] && !cir));
      tx_flush <= wr && addr == UEF_OFF_EVENT &&
                  (wdata[UEF_FC_TX_SOFT_RESET] || (!wdata[UEF_FC_EN] && !cir));
      fifo_on  <= fifo_eff;
    end
  end

  // shared format / bank address
  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_format <= UEF_LF_RESET;
      bank_select <= UEF_BS_RESET;
    end else if (wr && addr == UEF_OFF_FORMAT) begin
      bank_select <= wdata;
      if (!wdata[UEF_BS_ON] || bank1_code) begin
        line_format <= wdata;
      end
    end
  end

  // mode control and ir control, both simple software registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_control   <= 8'h00;
      ir_control_two <= 8'h00;
    end else if (wr && addr == UEF_OFF_MODE) begin
      mode_control   <= wdata;
    end else if (wr && addr == UEF_OFF_IRCTL) begin
      ir_control_two <= wdata;
    end
  end

  // decoded outputs; consumer ir holds the reset format in force
  always_ff @(posedge clk) begin
    if (!rstn) begin
      format      <= '0;
      op_mode_sel <= UEF_MODE_UART;
      active_bank <= 7'h00;
    end else begin
      op_mode_sel <= mode_control[7:UEF_MODE_LSB];
      active_bank <= bank_select[UEF_BS_ON] ? bank_select[6:0] : 7'h00;
      if (cir) begin
        format <= '0;
        format.char_bits <= UEF_CHAR_BASE;
      end else begin
        format.char_bits <= UEF_CHAR_BASE + {2'b00, line_format[1:0]};
        format.two_stop  <= line_format[UEF_LF_STB] &&
                            line_format[1:0] != 2'b00;
        format.half_stop <= line_format[UEF_LF_STB] &&
                            line_format[1:0] == 2'b00;
        format.parity_on <= line_format[UEF_LF_PEN];
        format.parity_value_fixed <= line_format[UEF_LF_STICK_PARITY];
        format.parity_const <= !line_format[UEF_LF_EPS];
        format.parity_even  <= line_format[UEF_LF_EPS];
        format.send_break   <= line_format[UEF_LF_BRK];
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        UEF_OFF_EVENT:  rdata <= event_flags_ext;
        UEF_OFF_FORMAT: rdata <= bank_select;
        UEF_OFF_MODE:   rdata <= mode_control;
        UEF_OFF_IRCTL:  rdata <= ir_control_two;
        UEF_OFF_SHADOW: rdata <= (bank_select == UEF_BANK3_CODE) ?
                                 line_format : 8'h00;
        default:        rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// >>> shared/uef_pkg.sv
// package for the uart event, fifo control and link format register block
package uef_pkg;

  // register offsets
  localparam logic [2:0] UEF_OFF_EVENT   = 3'h2;
  localparam logic [2:0] UEF_OFF_FORMAT  = 3'h3;
  localparam logic [2:0] UEF_OFF_MODE    = 3'h4;
  localparam logic [2:0] UEF_OFF_IRCTL   = 3'h5;
  localparam logic [2:0] UEF_OFF_SHADOW  = 3'h7;

  // bank 3 holds the line format shadow
  localparam logic [7:0] UEF_BANK3_CODE  = 8'he4;

  // event flag bit positions
  localparam int UEF_EV_RXHDL = 0;
  localparam int UEF_EV_TXLDL = 1;
  localparam int UEF_EV_LINK  = 2;
  localparam int UEF_EV_MODEM = 3;
  localparam int UEF_EV_DMA   = 4;
  localparam int UEF_EV_TX_EMPTY_STATUS = 5;

  // fifo control bit positions
  localparam int UEF_FC_EN    = 0;
  localparam int UEF_FC_RX_SOFT_RESET  = 1;
  localparam int UEF_FC_TX_SOFT_RESET  = 2;
  localparam int UEF_FC_TXTH  = 4;
  localparam int UEF_FC_RXTH  = 6;

  // line format, bank select, mode and ir control bit positions
  localparam int UEF_LF_STB   = 2;
  localparam int UEF_LF_PEN   = 3;
  localparam int UEF_LF_EPS   = 4;
  localparam int UEF_LF_STICK_PARITY  = 5;
  localparam int UEF_LF_BRK   = 6;
  localparam int UEF_BS_ON    = 7;
  localparam int UEF_MODE_LSB = 5;
  localparam int UEF_IRSEL    = 1;

  localparam logic [7:0] UEF_LF_RESET = 8'h00;
  localparam logic [7:0] UEF_BS_RESET = 8'h00;
  localparam logic [7:0] UEF_FC_RESET = 8'h00;

  // 5 data bits after reset is code 00
  localparam logic [3:0] UEF_CHAR_BASE = 4'h5;

  // operating modes
  localparam logic [2:0] UEF_MODE_UART = 3'h0;
  localparam logic [2:0] UEF_MODE_AKIR = 3'h2;
  localparam logic [2:0] UEF_MODE_SIR  = 3'h3;
  localparam logic [2:0] UEF_MODE_CIR  = 3'h6;

  // fifo thresholds indexed by code, 16 and 32 deep
  localparam logic [5:0] UEF_TX16 [4] = '{6'h01, 6'h03, 6'h09, 6'h0d};
  localparam logic [5:0] UEF_TX32 [4] = '{6'h01, 6'h07, 6'h11, 6'h19};
  localparam logic [5:0] UEF_RX16 [4] = '{6'h01, 6'h04, 6'h08, 6'h0e};
  localparam logic [5:0] UEF_RX32 [4] = '{6'h01, 6'h08, 6'h10, 6'h1a};

  // status of the receive and transmit paths
  typedef struct packed {
    logic       rx_holding_full;
    logic       rx_timeout;
    logic       tx_holding_empty;
    logic       tx_empty_status;
    logic       parity_error;
    logic       framing_error;
    logic       break_detect;
    logic       rx_overrun;
    logic       tx_underrun;
    logic [3:0] modem_status_bits;
    logic       terminal_count;
    logic [5:0] rx_level;
    logic [5:0] tx_level;
  } uef_path_t;

  // clear strobes from reads and writes of the source registers
  typedef struct packed {
    logic rx_data_read;
    logic tx_data_write;
    logic line_status_read;
    logic modem_status_read;
  } uef_ack_t;

  // decoded link format presented to the serial engine
  typedef struct packed {
    logic [3:0] char_bits;
    logic       two_stop;
    logic       half_stop;
    logic       parity_on;
    logic       parity_value_fixed;
    logic       parity_const;
    logic       parity_even;
    logic       send_break;
  } uef_format_t;

endpackage

// >>> test/uef_far.sv
// far side model: serial engine and line status seen by the register block
`timescale 1ns/1ps
module uef_far
  import uef_pkg::*;
(
  // clock
  input  wire logic               clk,
  // levels and one-cycle event requests from the bench
  input  wire uef_pkg::uef_path_t lvl,
  input  wire logic [3:0]         hit,
  // status towards the block
  output uef_pkg::uef_path_t      path
);
  // error and count requests come up one cycle after the bench raises them
  always_ff @(posedge clk) begin
    path                <= lvl;
    path.parity_error   <= hit[0];
    path.rx_overrun     <= hit[1];
    path.tx_underrun    <= hit[2];
    path.terminal_count <= hit[3];
  end
endmodule

// >>> test/uef_regs_asserts.sv
// port assertions for the event, fifo control and format register block
`timescale 1ns/1ps
module uef_regs_asserts
  import uef_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter bit LEGACY_DMA = 1'b1
) (
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic [2:0]          addr,
  input wire logic [7:0]          wdata,
  input wire logic                wr,
  input wire logic                rd,
  input wire logic [7:0]          rdata,
  input wire uef_pkg::uef_path_t  path,
  input wire uef_pkg::uef_ack_t   ack,
  input wire logic                fifo_on,
  input wire logic                rx_flush,
  input wire logic                tx_flush,
  input wire uef_pkg::uef_format_t format,
  input wire logic [2:0]          op_mode_sel,
  input wire logic [6:0]          active_bank
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic       fw;
  logic       cir;
  logic [7:0] wd1;
  logic [7:0] wd2;
  assign fw  = wr && addr == UEF_OFF_FORMAT && !wdata[7] && op_mode_sel != UEF_MODE_CIR;
  assign cir = op_mode_sel == UEF_MODE_CIR;
  // write data two cycles back, to match the output stage of the format
  always_ff @(posedge clk) begin
    wd1 <= wdata;
    wd2 <= wd1;
  end
  a_evt_top_zero: assert property ($past(rd) && $past(addr) == UEF_OFF_EVENT |-> rdata[7:6] == 2'b00)
    else $error("event read shows reserved bits set");
  a_rx_soft_reset_flush: assert property (wr && addr == UEF_OFF_EVENT && wdata[1] |-> ##[1:2] rx_flush)
    else $error("rx soft reset gave no flush");
  a_tx_soft_reset_flush: assert property (wr && addr == UEF_OFF_EVENT && wdata[2] |-> ##[1:2] tx_flush)
    else $error("tx soft reset gave no flush");
  a_fifo_off_flush: assert property (wr && addr == UEF_OFF_EVENT && !wdata[0] && fifo_on && !cir
    |-> ##[1:2] (rx_flush && tx_flush))
    else $error("fifo disable did not empty both fifos");
  a_cir_fifo_on: assert property (cir && $past(cir) |-> fifo_on)
    else $error("fifos off in consumer ir mode");
  a_cir_fmt_reset: assert property (cir && $past(cir)
    |-> format.char_bits == UEF_CHAR_BASE && !format.send_break && !format.parity_on)
    else $error("format active in consumer ir mode");
  a_len_from_write: assert property (fw |-> ##2 format.char_bits == UEF_CHAR_BASE + wd2[1:0])
    else $error("character length differs from write");
  a_brk_from_write: assert property (fw |-> ##2 format.send_break == wd2[6])
    else $error("break differs from write");
  a_bank_zero: assert property (wr && addr == UEF_OFF_FORMAT && !wdata[7] |-> ##2 active_bank == 7'h00)
    else $error("bank not zero after bit 7 low write");
  a_gated_keep: assert property (wr && addr == UEF_OFF_FORMAT && wdata[7] && wdata[6] && wdata[1:0] == 2'b00
    |-> ##2 $stable(format))
    else $error("format changed by a bank write");
endmodule
bind uef_regs uef_regs_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .LEGACY_DMA(LEGACY_DMA)) chk_u (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .path(path), .ack(ack), .fifo_on(fifo_on), .rx_flush(rx_flush), .tx_flush(tx_flush),
  .format(format), .op_mode_sel(op_mode_sel), .active_bank(active_bank));

// >>> test/uef_regs_bench.sv
// self-checking bench for the event, fifo control and format register block
`timescale 1ns/1ps
module uef_regs_bench;
  import uef_pkg::*;
  logic        clk, rstn, wr, rd, fifo_on, rx_flush, tx_flush;
  logic [2:0]  addr, op_mode_sel;
  logic [7:0]  wdata, rdata;
  logic [6:0]  active_bank;
  logic [3:0]  hit;
  uef_path_t   lvl, path;
  uef_ack_t    ack;
  uef_format_t format;
  int          errors, n_checks, cyc;
  uef_regs #(.FIFO_DEPTH(16), .LEGACY_DMA(1'b1)) dut_u (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .path(path), .ack(ack), .fifo_on(fifo_on), .rx_flush(rx_flush), .tx_flush(tx_flush),
    .format(format), .op_mode_sel(op_mode_sel), .active_bank(active_bank));
  uef_far far_u (.clk(clk), .lvl(lvl), .hit(hit), .path(path));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a hang would otherwise leave the run without a verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic setl(input uef_path_t v);
    @(posedge clk);
    lvl <= v;
    idle(3);
  endtask
  task automatic pulse(input logic [3:0] h, input uef_ack_t k);
    @(posedge clk);
    hit <= h;
    ack <= k;
    @(posedge clk);
    hit <= 4'h0;
    ack <= '0;
    idle(3);
  endtask
  task automatic t_fmt;
    uef_path_t v;
    v = '0;
    v.tx_empty_status = 1'b1;
    setl(v);
    for (int i = 0; i < 4; i++) begin
      put(UEF_OFF_FORMAT, 8'h44 | 8'(i));
      idle(2);
      chk(format.char_bits, UEF_CHAR_BASE + 4'(i));
      chk(format.send_break, 1'b1);
      chk(i == 0 ? format.half_stop : format.two_stop, 1'b1);
    end
    for (int i = 0; i < 8; i++) begin
      put(UEF_OFF_FORMAT, 8'(i << 3));
      idle(2);
      chk(format.parity_on, i[0]);
      if (i[0]) chk(format.parity_value_fixed, i[2]);
      if (i[0] && i[2]) chk(format.parity_const, !i[1]);
      if (i[0] && !i[2]) chk(format.parity_even, i[1]);
    end
  endtask
  task automatic t_bank;
    put(UEF_OFF_FORMAT, 8'h03);
    put(UEF_OFF_FORMAT, UEF_BANK3_CODE);
    get(UEF_OFF_FORMAT, UEF_BANK3_CODE);
    get(UEF_OFF_SHADOW, 8'h03);
    chk(format.char_bits, 4'h8);
    chk(active_bank, UEF_BANK3_CODE[6:0]);
    put(UEF_OFF_FORMAT, 8'h82);
    idle(2);
    chk(format.char_bits, 4'h7);
    put(UEF_OFF_FORMAT, 8'h00);
    get(UEF_OFF_FORMAT, 8'h00);
    chk(active_bank, 7'h00);
    get(3'h6, 8'h00);
  endtask
  task automatic t_fifo;
    uef_path_t v;
    put(UEF_OFF_EVENT, 8'h01);
    idle(2);
    chk(fifo_on, 1'b1);
    for (int c = 0; c < 4; c++) begin
      v = '0;
      put(UEF_OFF_EVENT, 8'(c * 8'h50 + 1));
      v.rx_level = UEF_RX16[c] - 6'h01;
      v.tx_level = UEF_TX16[c];
      setl(v);
      get(UEF_OFF_EVENT, 8'h00);
      v.rx_level = UEF_RX16[c];
      v.tx_level = UEF_TX16[c] - 6'h01;
      setl(v);
      get(UEF_OFF_EVENT, 8'h03);
    end
    // tx level held at the code 11 threshold so only the timeout shows
    v = '0;
    v.rx_timeout = 1'b1;
    v.tx_level = UEF_TX16[3];
    setl(v);
    get(UEF_OFF_EVENT, 8'h01);
    put(UEF_OFF_EVENT, 8'h07);
    #1;
    chk({rx_flush, tx_flush}, 2'b11);
    put(UEF_OFF_EVENT, 8'h00);
    #1;
    chk({rx_flush, tx_flush}, 2'b11);
    idle(2);
    chk(fifo_on, 1'b0);
  endtask
  task automatic t_evt;
    uef_path_t v;
    v = '0;
    v.rx_holding_full = 1'b1;
    v.tx_holding_empty = 1'b1;
    v.tx_empty_status = 1'b1;
    setl(v);
    get(UEF_OFF_EVENT, 8'h23);
    setl('0);
    pulse(4'h1, '0);
    get(UEF_OFF_EVENT, 8'h04);
    get(UEF_OFF_EVENT, 8'h04);
    pulse(4'h0, 4'b0010);
    get(UEF_OFF_EVENT, 8'h00);
    pulse(4'h2, '0);
    get(UEF_OFF_EVENT, 8'h04);
    pulse(4'h0, 4'b0010);
    pulse(4'h8, '0);
    get(UEF_OFF_EVENT, 8'h10);
    get(UEF_OFF_EVENT, 8'h00);
    v = '0;
    v.modem_status_bits = 4'h4;
    setl(v);
    get(UEF_OFF_EVENT, 8'h08);
    put(UEF_OFF_MODE, 8'h60);
    put(UEF_OFF_IRCTL, 8'h02);
    idle(2);
    get(UEF_OFF_EVENT, 8'h00);
    setl('0);
    pulse(4'h0, 4'b0001);
    put(UEF_OFF_IRCTL, 8'h00);
    put(UEF_OFF_MODE, 8'h00);
    idle(2);
    get(UEF_OFF_EVENT, 8'h00);
  endtask
  task automatic t_cir;
    logic [2:0] modes [4] = '{UEF_MODE_UART, UEF_MODE_AKIR, UEF_MODE_SIR, UEF_MODE_CIR};
    for (int m = 0; m < 4; m++) begin
      put(UEF_OFF_MODE, {modes[m], 5'h00});
      idle(2);
      chk(op_mode_sel, modes[m]);
    end
    chk(fifo_on, 1'b1);
    put(UEF_OFF_EVENT, 8'h00);
    put(UEF_OFF_FORMAT, 8'h5f);
    idle(3);
    chk(fifo_on, 1'b1);
    chk(format.char_bits, UEF_CHAR_BASE);
    // an empty tx fifo sits below threshold, hence bit 1
    pulse(4'h1, '0);
    get(UEF_OFF_EVENT, 8'h02);
    pulse(4'h4, '0);
    get(UEF_OFF_EVENT, 8'h06);
    pulse(4'h0, 4'b0010);
    pulse(4'h2, '0);
    get(UEF_OFF_EVENT, 8'h06);
    pulse(4'h0, 4'b0010);
    put(UEF_OFF_MODE, 8'h00);
  endtask
  initial begin
    rstn  = 1'b0;
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = 3'h0;
    wdata = 8'h00;
    hit   = 4'h0;
    ack   = '0;
    lvl   = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    idle(1);
    chk(format.char_bits, UEF_CHAR_BASE);
    chk(fifo_on, 1'b0);
    get(UEF_OFF_FORMAT, UEF_BS_RESET);
    t_fmt;
    t_bank;
    t_fifo;
    t_evt;
    t_cir;
    tally_and_finish;
  end
endmodule
